// *** src/cit_timing.sv ***
/*
  cit_timing: computes the clock and bus-cycle cost of one instruction.
  Assumes requests come from logic on clk_sys; one result per request,
  registered, one cycle later. No back-pressure: the consumer must take it.
*/
// How it works
// RULE1 - each bus cycle is four clocks; wait states are added per bus cycle
// RULE2 - every answer gives total clocks, then read count, then write count
// RULE3 - address cost covers extension words and operand read, never writes
// RULE4 - indirect and postincrement 4(1/0) or 8(2/0); predecrement 6 or 10
// RULE5 - register plus displacement costs 8(2/0), long 12(3/0)
// RULE6 - indexed, register or counter based, costs 10(2/0), long 14(3/0)
// RULE7 - index register width never changes indexed cost
// RULE8 - counter relative with displacement costs 8(2/0), long 12(3/0)
// RULE9 - move costs already hold fetch, reads and writes; no extra address
// RULE10 - byte/word move: reg-reg 4(1/0), reg-ind 8(1/1), abs-abs 28(6/1)
// RULE11 - long move: reg-reg 4(1/0), reg-ind 12(1/2), abs-abs 36(7/2)
// RULE12 - standard costs hold operation, store and next fetch, plus address
// RULE13 - byte/word add: address reg 8(1/0), data reg 4(1/0), memory 8(1/1)
// RULE14 - byte/word compare: addr reg 6(1/0), data reg 4(1/0), plus address
// RULE15 - signed divide at most 158, unsigned 140 clocks, one read
// RULE16 - multiplies at most 70 clocks with one read, plus address
// RULE17 - multiply takes 38+2n; n is ones or bit-pair changes of source
// RULE18 - address cost is added only where marked, clocks and counts apart
// RULE19 - register direct operands add nothing for every size
`timescale 1ns/1ps

module cit_timing (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire cit_pkg::cit_req_t req,
  output logic respValid,
  output cit_pkg::cit_cost_t resp
);

  logic validReg;
  logic validNext;
  cit_pkg::cit_cost_t costReg;
  cit_pkg::cit_cost_t costNext;
  logic [15:0] pairBits;
  logic [4:0] mulCount;
  logic [7:0] srcClk;
  logic [3:0] srcRd;
  logic [7:0] dstClk;
  logic [3:0] dstRd;
  logic [3:0] words;
  logic [7:0] baseClk;
  logic [15:0] sumClk;
  logic [3:0] sumRd;
  logic [3:0] sumWr;
  logic [8:0] waitClk;

  // per-bit multiply weight: the bit itself, or its change from the bit
  // below (a zero below bit 0) for the signed form
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_pair
      if (gi == 0)
      begin : g_low
        // the appended zero makes the signed change equal the bit itself
        assign pairBits[gi] = req.operand[0];
      end
      else
      begin : g_up
        assign pairBits[gi] = (req.op == cit_pkg::OP_SIGNED_MULTIPLY) ?
          (req.operand[gi] ^ req.operand[gi-1]) : req.operand[gi];
      end
    end
  endgenerate

  // cost tables looked up for both modes; the size picks the column
  always_comb
  begin
    mulCount = 5'h00;
    for (int k = 0; k < 16; k++)
    begin
      mulCount = mulCount + {4'h0, pairBits[k]}; // see RULE17
    end
    words = (req.size == cit_pkg::SZ_LONG) ?
      cit_pkg::WORDS_L : cit_pkg::WORDS_BW;
    if (req.size == cit_pkg::SZ_LONG)
    begin
      srcClk = cit_pkg::EA_CLK_L[req.srcMode]; // see RULE4
      srcRd = cit_pkg::EA_RD_L[req.srcMode]; // see RULE3
      dstClk = cit_pkg::EA_CLK_L[req.dstMode];
      dstRd = cit_pkg::EA_RD_L[req.dstMode];
    end
    else
    begin
      srcClk = cit_pkg::EA_CLK_BW[req.srcMode]; // see RULE5
      srcRd = cit_pkg::EA_RD_BW[req.srcMode]; // see RULE6
      dstClk = cit_pkg::EA_CLK_BW[req.dstMode]; // see RULE8
      dstRd = cit_pkg::EA_RD_BW[req.dstMode]; // see RULE7
    end
  end

  // total cost; long add to a register pays the slower base when the
  // source is immediate or needs no bus read of its own
  always_comb
  begin
    baseClk = 8'h00;
    sumClk = 16'h0000;
    sumRd = 4'h0;
    sumWr = 4'h0;
    case (req.op)
      cit_pkg::OP_MOVE:
      begin
        // a move destination spends its read slots as writes
        sumWr = 4'h0;
        if (req.dstMode != cit_pkg::EA_DATA_REG &&
            req.dstMode != cit_pkg::EA_ADDR_REG)
        begin
          sumWr = words; // see RULE10
          if (req.dstMode == cit_pkg::EA_PREDEC)
          begin
            baseClk = (req.size == cit_pkg::SZ_LONG) ?
              cit_pkg::PREDEC_DST_CLK_L : cit_pkg::PREDEC_DST_CLK_BW;
          end
          else
          begin
            baseClk = dstClk;
          end
        end
        sumClk = {8'h00, cit_pkg::BUS_CYCLE_CLK} + {8'h00, srcClk} +
          {8'h00, baseClk}; // see RULE9
        sumRd = cit_pkg::FETCH_READS + srcRd +
          ((sumWr == 4'h0) ? 4'h0 : (dstRd - sumWr)); // see RULE11
      end
      default:
      begin
        case (req.op)
          cit_pkg::OP_ADD_ADDR_REG:
            baseClk = (req.size == cit_pkg::SZ_LONG) ?
              ((srcRd == 4'h0 || req.srcMode == cit_pkg::EA_IMM) ?
              cit_pkg::ADD_REG_L_RD_CLK : cit_pkg::ADD_REG_L_CLK) :
              cit_pkg::ADD_ADDR_BW_CLK; // see RULE13
          cit_pkg::OP_ADD_DATA_REG:
            baseClk = (req.size == cit_pkg::SZ_LONG) ?
              ((srcRd == 4'h0 || req.srcMode == cit_pkg::EA_IMM) ?
              cit_pkg::ADD_REG_L_RD_CLK : cit_pkg::ADD_REG_L_CLK) :
              cit_pkg::ADD_DATA_BW_CLK;
          cit_pkg::OP_ADD_MEM:
            baseClk = (req.size == cit_pkg::SZ_LONG) ?
              cit_pkg::ADD_MEM_L_CLK : cit_pkg::ADD_MEM_BW_CLK;
          cit_pkg::OP_COMPARE_ADDR_REG:
            baseClk = (req.size == cit_pkg::SZ_LONG) ?
              cit_pkg::COMPARE_L_CLK : cit_pkg::COMPARE_ADDR_BW_CLK;
          cit_pkg::OP_COMPARE_DATA_REG:
            baseClk = (req.size == cit_pkg::SZ_LONG) ?
              cit_pkg::COMPARE_L_CLK : cit_pkg::COMPARE_DATA_BW_CLK;
          cit_pkg::OP_SIGNED_DIVIDE:
            baseClk = cit_pkg::SIGNED_DIVIDE_CLK; // see RULE15
          cit_pkg::OP_UNSIGNED_DIVIDE:
            baseClk = cit_pkg::UNSIGNED_DIVIDE_CLK;
          default:
            baseClk = cit_pkg::MULTIPLY_BASE_CLK +
              {2'b00, mulCount, 1'b0}; // see RULE16
        endcase
        // marked entries add the memory operand's address cost
        if (req.op == cit_pkg::OP_ADD_MEM)
        begin
          sumClk = {8'h00, baseClk} + {8'h00, dstClk}; // see RULE18
          sumRd = cit_pkg::FETCH_READS + dstRd; // see RULE12
          sumWr = words;
        end
        else
        begin
          sumClk = {8'h00, baseClk} + {8'h00, srcClk}; // see RULE19
          sumRd = cit_pkg::FETCH_READS + srcRd; // see RULE14
          sumWr = 4'h0;
        end
      end
    endcase
  end

  // wait states stretch every bus cycle, reads and writes alike
  always_comb
  begin
    waitClk = ({5'h00, sumRd} + {5'h00, sumWr}) *
      {5'h00, req.waitStates}; // see RULE1
    validNext = reqValid;
    costNext = costReg;
    if (reqValid)
    begin
      costNext.clocks = sumClk + {7'h00, waitClk};
      costNext.reads = sumRd; // see RULE2
      costNext.writes = sumWr;
    end
  end

  // result registers; the last answer holds until the next request
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      validReg <= 1'b0;
      costReg <= cit_pkg::COST_RESET;
    end
    else
    begin
      validReg <= validNext;
      costReg <= costNext;
    end
  end

  assign respValid = validReg;
  assign resp = costReg;

  resp_latency_a: assert property ( // see RULE2
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid |=> respValid)
    else $error("answer missing one cycle after request");

  addr_nowrite_a: assert property ( // see RULE3
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid && req.op != cit_pkg::OP_MOVE &&
    req.op != cit_pkg::OP_ADD_MEM |=> resp.writes == 4'h0)
    else $error("address calculation produced a write");

  indirect_cost_a: assert property ( // see RULE4
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid && req.op == cit_pkg::OP_ADD_DATA_REG &&
    req.size == cit_pkg::SZ_BYTE_WORD && req.srcMode == cit_pkg::EA_PREDEC &&
    req.waitStates == 4'h0 |=> resp.clocks == 16'h000a && resp.reads == 4'h2)
    else $error("predecrement cost wrong");

  disp_long_a: assert property ( // see RULE5
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid && req.op == cit_pkg::OP_COMPARE_DATA_REG &&
    req.size == cit_pkg::SZ_LONG && req.srcMode == cit_pkg::EA_DISP &&
    req.waitStates == 4'h0 |=> resp.clocks == 16'h0012 && resp.reads == 4'h4)
    else $error("displacement long cost wrong");

  index_cost_a: assert property ( // see RULE6
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid && req.op == cit_pkg::OP_COMPARE_DATA_REG &&
    req.size == cit_pkg::SZ_BYTE_WORD && req.waitStates == 4'h0 &&
    (req.srcMode == cit_pkg::EA_INDEX || req.srcMode == cit_pkg::EA_PC_INDEX)
    |=> resp.clocks == 16'h000e && resp.reads == 4'h3)
    else $error("indexed cost wrong");

  move_regs_a: assert property ( // see RULE19
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid && req.op == cit_pkg::OP_MOVE && req.waitStates == 4'h0 &&
    req.srcMode == cit_pkg::EA_ADDR_REG && req.dstMode == cit_pkg::EA_DATA_REG
    |=> resp.clocks == 16'h0004 && resp.reads == 4'h1 && resp.writes == 4'h0)
    else $error("register move cost wrong");

  move_absl_a: assert property ( // see RULE11
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid && req.op == cit_pkg::OP_MOVE && req.waitStates == 4'h0 &&
    req.size == cit_pkg::SZ_LONG && req.srcMode == cit_pkg::EA_ABS_LONG &&
    req.dstMode == cit_pkg::EA_ABS_LONG
    |=> resp.clocks == 16'h0024 && resp.reads == 4'h7 && resp.writes == 4'h2)
    else $error("long absolute move cost wrong");

  wait_stretch_a: assert property ( // see RULE1
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid && req.op == cit_pkg::OP_MOVE &&
    req.size == cit_pkg::SZ_BYTE_WORD &&
    req.srcMode == cit_pkg::EA_DATA_REG && req.dstMode == cit_pkg::EA_IND
    |=> resp.clocks == 16'h0008 + {11'h000, $past(req.waitStates), 1'b0})
    else $error("wait states not added per bus cycle");

  divide_cost_a: assert property ( // see RULE15
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid && req.op == cit_pkg::OP_SIGNED_DIVIDE &&
    req.waitStates == 4'h0 &&
    req.srcMode == cit_pkg::EA_DATA_REG |=> resp.clocks == 16'h009e)
    else $error("signed divide cost wrong");

  multiply_cap_a: assert property ( // see RULE16
    @(posedge clk_sys) disable iff (!rst_n)
    reqValid && req.waitStates == 4'h0 &&
    req.srcMode == cit_pkg::EA_DATA_REG &&
    (req.op == cit_pkg::OP_SIGNED_MULTIPLY ||
    req.op == cit_pkg::OP_UNSIGNED_MULTIPLY)
    |=> resp.clocks <= {8'h00, cit_pkg::MULTIPLY_MAX_CLK} &&
    resp.reads == 4'h1)
    else $error("multiply exceeds its bound");

endmodule

// *** include/cit_pkg.sv ***
/*
  cit_pkg: types and constants for the instruction cycle-cost calculator.
  Assumes one synchronous consumer (cit_timing) on a single clock.
*/
package cit_pkg;

  // operand addressing modes, index order matches the cost tables below
  typedef enum logic [3:0] {
    EA_DATA_REG  = 4'h0,
    EA_ADDR_REG  = 4'h1,
    EA_IND       = 4'h2,
    EA_POSTINC   = 4'h3,
    EA_PREDEC    = 4'h4,
    EA_DISP      = 4'h5,
    EA_INDEX     = 4'h6,
    EA_ABS_SHORT = 4'h7,
    EA_ABS_LONG  = 4'h8,
    EA_PC_DISP   = 4'h9,
    EA_PC_INDEX  = 4'ha,
    EA_IMM       = 4'hb
  } cit_ea_t;

  localparam int EA_COUNT = 12;

  // instruction classes whose cost the block computes
  typedef enum logic [3:0] {
    OP_MOVE              = 4'h0,
    OP_ADD_ADDR_REG      = 4'h1,
    OP_ADD_DATA_REG      = 4'h2,
    OP_ADD_MEM           = 4'h3,
    OP_COMPARE_ADDR_REG  = 4'h4,
    OP_COMPARE_DATA_REG  = 4'h5,
    OP_SIGNED_DIVIDE     = 4'h6,
    OP_UNSIGNED_DIVIDE   = 4'h7,
    OP_SIGNED_MULTIPLY   = 4'h8,
    OP_UNSIGNED_MULTIPLY = 4'h9
  } cit_op_t;

  typedef enum logic {
    SZ_BYTE_WORD = 1'b0,
    SZ_LONG      = 1'b1
  } cit_size_t;

  typedef struct packed {
    cit_op_t   op;
    cit_size_t size;
    cit_ea_t   srcMode;
    cit_ea_t   dstMode;
    logic [15:0] operand;
    logic [3:0]  waitStates;
  } cit_req_t;

  typedef struct packed {
    logic [15:0] clocks;
    logic [3:0]  reads;
    logic [3:0]  writes;
  } cit_cost_t;

  localparam cit_cost_t COST_RESET = '0;

  // effective-address cost, clocks and bus reads, per mode
  localparam logic [7:0] EA_CLK_BW [EA_COUNT] = '{
    8'h00, 8'h00, 8'h04, 8'h04, 8'h06, 8'h08,
    8'h0a, 8'h08, 8'h0c, 8'h08, 8'h0a, 8'h04};
  localparam logic [7:0] EA_CLK_L [EA_COUNT] = '{
    8'h00, 8'h00, 8'h08, 8'h08, 8'h0a, 8'h0c,
    8'h0e, 8'h0c, 8'h10, 8'h0c, 8'h0e, 8'h08};
  localparam logic [3:0] EA_RD_BW [EA_COUNT] = '{
    4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2,
    4'h2, 4'h2, 4'h3, 4'h2, 4'h2, 4'h1};
  localparam logic [3:0] EA_RD_L [EA_COUNT] = '{
    4'h0, 4'h0, 4'h2, 4'h2, 4'h2, 4'h3,
    4'h3, 4'h3, 4'h4, 4'h3, 4'h3, 4'h2};

  // a predecrement destination of a move skips the two decrement clocks
  localparam logic [7:0] PREDEC_DST_CLK_BW = 8'h04;
  localparam logic [7:0] PREDEC_DST_CLK_L  = 8'h08;

  // bus cycle length with no wait states; one opcode fetch per instruction
  localparam logic [7:0] BUS_CYCLE_CLK = 8'h04;
  localparam logic [3:0] FETCH_READS   = 4'h1;
  localparam logic [3:0] WORDS_BW      = 4'h1;
  localparam logic [3:0] WORDS_L       = 4'h2;

  // base costs of the standard instructions
  localparam logic [7:0] ADD_ADDR_BW_CLK  = 8'h08;
  localparam logic [7:0] ADD_DATA_BW_CLK  = 8'h04;
  localparam logic [7:0] ADD_MEM_BW_CLK   = 8'h08;
  localparam logic [7:0] ADD_REG_L_CLK    = 8'h06;
  localparam logic [7:0] ADD_REG_L_RD_CLK = 8'h08;
  localparam logic [7:0] ADD_MEM_L_CLK    = 8'h0c;
  localparam logic [7:0] COMPARE_ADDR_BW_CLK = 8'h06;
  localparam logic [7:0] COMPARE_DATA_BW_CLK = 8'h04;
  localparam logic [7:0] COMPARE_L_CLK       = 8'h06;
  localparam logic [7:0] SIGNED_DIVIDE_CLK   = 8'h9e;
  localparam logic [7:0] UNSIGNED_DIVIDE_CLK = 8'h8c;
  localparam logic [7:0] MULTIPLY_BASE_CLK   = 8'h26;
  localparam logic [7:0] MULTIPLY_MAX_CLK    = 8'h46;

endpackage

// *** verif/cit_consumer_model.sv ***
/*
  cit_consumer_model: the logic that takes cost answers from the block.
  Assumes one clk_sys domain; it never stalls, as the block cannot wait.
*/
`timescale 1ns/1ps

module cit_consumer_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic respValid,
  input wire cit_pkg::cit_cost_t resp,
  output int answerCount
);
  // every answer is counted at once; there is no way to hold one back
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      answerCount <= 0;
    else if (respValid)
      answerCount <= answerCount + 1;
  end
endmodule

// *** verif/cit_timing_tb_top.sv ***
/*
  cit_timing_tb_top: self-checking bench for the cycle-cost calculator.
  Assumes cit_timing answers exactly one cycle after each request.
*/
`timescale 1ns/1ps

module cit_timing_tb_top;
  logic clkSys = 1'b0;
  logic rstN = 1'b0;
  logic reqValid = 1'b0;
  cit_pkg::cit_req_t req = '0;
  logic respValid;
  cit_pkg::cit_cost_t resp;
  int answerCount;
  int numErrors = 0;
  int compares = 0;
  int sent = 0;

  // 250 MHz system clock
  always #2 clkSys = ~clkSys;

  cit_timing cit_timing_i (
    .clk_sys(clkSys),
    .rst_n(rstN),
    .reqValid(reqValid),
    .req(req),
    .respValid(respValid),
    .resp(resp)
  );

  cit_consumer_model cit_consumer_model_i (
    .clk_sys(clkSys),
    .rst_n(rstN),
    .respValid(respValid),
    .resp(resp),
    .answerCount(answerCount)
  );

  // request builder, wait states last
  function automatic cit_pkg::cit_req_t mk(cit_pkg::cit_op_t op,
    cit_pkg::cit_size_t sz, cit_pkg::cit_ea_t src, cit_pkg::cit_ea_t dst,
    logic [15:0] opnd, logic [3:0] ws);
    mk = '{op, sz, src, dst, opnd, ws};
  endfunction

  function automatic cit_pkg::cit_cost_t cc(int c, int r, int w);
    cc = '{16'(c), 4'(r), 4'(w)};
  endfunction

  task automatic check_cost(string name, cit_pkg::cit_cost_t exp,
    cit_pkg::cit_cost_t got);
    compares++;
    if (got !== exp)
    begin
      numErrors++;
      $display("[FAIL] %s expected %0d(%0d/%0d) seen %0d(%0d/%0d)", name,
        exp.clocks, exp.reads, exp.writes, got.clocks, got.reads, got.writes);
    end
  endtask

  task automatic check_bit(string name, logic exp, logic got);
    compares++;
    if (got !== exp)
    begin
      numErrors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // one request; its answer is judged one cycle after it stands
  task automatic run(string name, cit_pkg::cit_req_t r,
    cit_pkg::cit_cost_t exp);
    @(posedge clkSys);
    reqValid <= 1'b1;
    req <= r;
    @(posedge clkSys);
    reqValid <= 1'b0;
    #1;
    check_bit({name, " valid"}, 1'b1, respValid);
    check_cost(name, exp, resp);
    sent++;
  endtask

  // address modes priced through byte/word add and long compare
  task automatic test_ea();
    cit_pkg::cit_ea_t m[12] = '{cit_pkg::EA_DATA_REG, cit_pkg::EA_ADDR_REG,
      cit_pkg::EA_IND, cit_pkg::EA_POSTINC, cit_pkg::EA_PREDEC,
      cit_pkg::EA_DISP, cit_pkg::EA_INDEX, cit_pkg::EA_ABS_SHORT,
      cit_pkg::EA_ABS_LONG, cit_pkg::EA_PC_DISP, cit_pkg::EA_PC_INDEX,
      cit_pkg::EA_IMM};
    int cw[12] = '{0, 0, 4, 4, 6, 8, 10, 8, 12, 8, 10, 4};
    int rw[12] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 2, 2, 1};
    int cl[12] = '{0, 0, 8, 8, 10, 12, 14, 12, 16, 12, 14, 8};
    int rl[12] = '{0, 0, 2, 2, 2, 3, 3, 3, 4, 3, 3, 2};
    for (int i = 0; i < 12; i++)
    begin
      run("add ea", mk(cit_pkg::OP_ADD_DATA_REG, cit_pkg::SZ_BYTE_WORD,
        m[i], cit_pkg::EA_DATA_REG, 16'h0000, 4'h0),
        cc(4 + cw[i], 1 + rw[i], 0));
      run("compare long ea", mk(cit_pkg::OP_COMPARE_DATA_REG,
        cit_pkg::SZ_LONG, m[i], cit_pkg::EA_DATA_REG, 16'h0000, 4'h0),
        cc(6 + cl[i], 1 + rl[i], 0));
    end
    $display("test ea done");
  endtask

  // reset in mid-run clears the answer at once, then work resumes
  task automatic test_reset();
    run("pre reset", mk(cit_pkg::OP_UNSIGNED_DIVIDE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_DATA_REG, 16'h0, 4'h0),
      cc(140, 1, 0));
    @(posedge clkSys);
    rstN <= 1'b0;
    #1;
    sent = 0;
    check_bit("reset mid valid", 1'b0, respValid);
    check_cost("reset mid resp", cc(0, 0, 0), resp);
    repeat (2) @(posedge clkSys);
    rstN <= 1'b1;
    @(posedge clkSys);
    #1;
    check_bit("release valid", 1'b0, respValid);
    check_cost("release resp", cc(0, 0, 0), resp);
    run("post reset", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_IND, 16'h0, 4'h0),
      cc(8, 1, 1));
    $display("test reset done");
  endtask

  // moves carry their own operand costs
  task automatic test_move();
    run("mv rr", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_ADDR_REG, 16'h0, 4'h0),
      cc(4, 1, 0));
    run("mv ri", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_IND, 16'h0, 4'h0),
      cc(8, 1, 1));
    run("mv rpd", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_PREDEC, 16'h0, 4'h0),
      cc(8, 1, 1));
    run("mv imm disp", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_IMM, cit_pkg::EA_DISP, 16'h0, 4'h0),
      cc(16, 3, 1));
    run("mv aa", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_ABS_LONG, cit_pkg::EA_ABS_LONG, 16'h0, 4'h0),
      cc(28, 6, 1));
    run("mvl rr", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_LONG,
      cit_pkg::EA_ADDR_REG, cit_pkg::EA_DATA_REG, 16'h0, 4'h0),
      cc(4, 1, 0));
    run("mvl ri", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_LONG,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_IND, 16'h0, 4'h0),
      cc(12, 1, 2));
    run("mvl rpd", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_LONG,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_PREDEC, 16'h0, 4'h0),
      cc(12, 1, 2));
    run("mvl aa", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_LONG,
      cit_pkg::EA_ABS_LONG, cit_pkg::EA_ABS_LONG, 16'h0, 4'h0),
      cc(36, 7, 2));
    $display("test move done");
  endtask

  // add and compare base costs, memory destination priced by its mode
  task automatic test_std();
    run("add addr", mk(cit_pkg::OP_ADD_ADDR_REG, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_ADDR_REG, 16'h0, 4'h0),
      cc(8, 1, 0));
    run("add data", mk(cit_pkg::OP_ADD_DATA_REG, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_DATA_REG, 16'h0, 4'h0),
      cc(4, 1, 0));
    run("add mem", mk(cit_pkg::OP_ADD_MEM, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_IND, 16'h0, 4'h0),
      cc(12, 2, 1));
    run("compare addr", mk(cit_pkg::OP_COMPARE_ADDR_REG,
      cit_pkg::SZ_BYTE_WORD, cit_pkg::EA_IND, cit_pkg::EA_ADDR_REG, 16'h0,
      4'h0), cc(10, 2, 0));
    run("compare index", mk(cit_pkg::OP_COMPARE_DATA_REG,
      cit_pkg::SZ_BYTE_WORD, cit_pkg::EA_INDEX, cit_pkg::EA_DATA_REG, 16'h0,
      4'h0), cc(14, 3, 0));
    run("add long reg", mk(cit_pkg::OP_ADD_DATA_REG, cit_pkg::SZ_LONG,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_DATA_REG, 16'h0, 4'h0),
      cc(8, 1, 0));
    run("add long ind", mk(cit_pkg::OP_ADD_DATA_REG, cit_pkg::SZ_LONG,
      cit_pkg::EA_IND, cit_pkg::EA_DATA_REG, 16'h0, 4'h0),
      cc(14, 3, 0));
    run("add long imm", mk(cit_pkg::OP_ADD_ADDR_REG, cit_pkg::SZ_LONG,
      cit_pkg::EA_IMM, cit_pkg::EA_ADDR_REG, 16'h0, 4'h0),
      cc(16, 3, 0));
    run("add mem long", mk(cit_pkg::OP_ADD_MEM, cit_pkg::SZ_LONG,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_IND, 16'h0, 4'h0),
      cc(20, 3, 2));
    run("compare long", mk(cit_pkg::OP_COMPARE_ADDR_REG, cit_pkg::SZ_LONG,
      cit_pkg::EA_IND, cit_pkg::EA_ADDR_REG, 16'h0, 4'h0),
      cc(14, 3, 0));
    $display("test std done");
  endtask

  // divide ceilings and data-dependent multiply
  task automatic test_divmul();
    run("sdiv", mk(cit_pkg::OP_SIGNED_DIVIDE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_DATA_REG, 16'h0, 4'h0),
      cc(158, 1, 0));
    run("udiv", mk(cit_pkg::OP_UNSIGNED_DIVIDE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_DATA_REG, 16'h0, 4'h0),
      cc(140, 1, 0));
    run("umul max", mk(cit_pkg::OP_UNSIGNED_MULTIPLY, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_DATA_REG, 16'hffff, 4'h0),
      cc(70, 1, 0));
    run("smul max", mk(cit_pkg::OP_SIGNED_MULTIPLY, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_DATA_REG, 16'h5555, 4'h0),
      cc(70, 1, 0));
    run("umul f0", mk(cit_pkg::OP_UNSIGNED_MULTIPLY, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_DATA_REG, 16'h00f0, 4'h0),
      cc(46, 1, 0));
    run("smul f0", mk(cit_pkg::OP_SIGNED_MULTIPLY, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_DATA_REG, 16'h00f0, 4'h0),
      cc(42, 1, 0));
    $display("test divmul done");
  endtask

  // slow memory stretches every bus cycle
  task automatic test_waits();
    run("mv ri ws", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_IND, 16'h0, 4'h2),
      cc(12, 1, 1));
    run("mvl ri ws", mk(cit_pkg::OP_MOVE, cit_pkg::SZ_LONG,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_IND, 16'h0, 4'h3),
      cc(21, 1, 2));
    run("add mem ws", mk(cit_pkg::OP_ADD_MEM, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_DATA_REG, cit_pkg::EA_IND, 16'h0, 4'h1),
      cc(15, 2, 1));
    $display("test waits done");
  endtask

  // back-to-back requests, then an idle request that must be ignored
  task automatic test_b2b();
    @(posedge clkSys);
    reqValid <= 1'b1;
    req <= mk(cit_pkg::OP_MOVE, cit_pkg::SZ_BYTE_WORD, cit_pkg::EA_DATA_REG,
      cit_pkg::EA_DATA_REG, 16'h0, 4'h0);
    @(posedge clkSys);
    req <= mk(cit_pkg::OP_SIGNED_DIVIDE, cit_pkg::SZ_BYTE_WORD,
      cit_pkg::EA_IND, cit_pkg::EA_DATA_REG, 16'h0, 4'h0);
    #1;
    check_cost("b2b first", cc(4, 1, 0), resp);
    @(posedge clkSys);
    reqValid <= 1'b0;
    req <= mk(cit_pkg::OP_MOVE, cit_pkg::SZ_LONG, cit_pkg::EA_ABS_LONG,
      cit_pkg::EA_ABS_LONG, 16'h0, 4'h0);
    #1;
    check_bit("b2b valid", 1'b1, respValid);
    check_cost("b2b second", cc(162, 2, 0), resp);
    @(posedge clkSys);
    #1;
    check_bit("idle valid", 1'b0, respValid);
    check_cost("idle hold", cc(162, 2, 0), resp);
    sent += 2;
    $display("test b2b done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge clkSys);
    #1;
    check_bit("reset valid", 1'b0, respValid);
    check_cost("reset resp", cc(0, 0, 0), resp);
    @(posedge clkSys);
    rstN <= 1'b1;
    test_reset();
    test_ea();
    test_move();
    test_std();
    test_divmul();
    test_waits();
    test_b2b();
    repeat (2) @(posedge clkSys);
    check_bit("answer count", 1'b1, answerCount == sent);
    tally_and_finish();
  end

  // the tests need under 300 cycles; 5000 means a hang
  initial
  begin
    #20000;
    numErrors++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
